// file: rsa_pkg.sv
// Contract
// - Six reset sources handled separately
// - Hold register, ROM offset: power-on/shutdown only
// - Enabled pin low past minimum resets system
// - Writing software bit one resets system
// - Software bit clears itself
// - 8-bit watchdog steps every 131072 clocks
// - Enabled watchdog overflow resets system
// - Shutdown wake: wake, then global reset
// - Sleep wake: partial reset after power ready
// - Retained key registers untouched by sleep
// - Regenerative state reset on wake
// - Non-retained registers all reset on wake
// - Local reset spares retained key registers
// - Protected writes only in safe mode
// - Unlock by 0x57 then 0xA8
// - Safe window lasts 16 clocks
// - Window expiry relocks automatically
// - Writing 0x00 relocks at once
// - Unexpected signature byte relocks
// - Watchdog presettable, wraps FF to 00
package rsa_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SIG = 8'h40;
   localparam logic [7:0] IDX_CHIP = 8'h41;
   localparam logic [7:0] IDX_SAFE_ID = 8'h42;
   localparam logic [7:0] IDX_WDOG = 8'h43;
   localparam logic [7:0] IDX_STATUS = 8'h44;
   localparam logic [7:0] IDX_CTRL = 8'h46;
   localparam logic [7:0] IDX_HOLD = 8'h47;
   localparam logic [7:0] IDX_ROM = 8'h48;

   ////////////////////////////////////////////////////////////////////////
   // Unlock keys and window
   localparam logic [7:0] KEY_FIRST = 8'h57;
   localparam logic [7:0] KEY_SECOND = 8'hA8;
   localparam logic [7:0] KEY_EXIT = 8'h00;
   localparam int SAFE_CYC = 16;
   localparam logic [3:0] SAFE_LOAD = 4'(SAFE_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS = 4;
   localparam int MR_MIN_NS = 100;
   localparam logic [7:0] MR_CYC = 8'((MR_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] SYS_RST_CYC = 5'h10;
   localparam logic [4:0] LOC_RST_CYC = 5'h04;
   localparam int WDOG_DIV_DEF = 131072;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and cause codes
   localparam logic [7:0] WDOG_RST = 8'h00;
   localparam logic [7:0] HOLD_RST = 8'h00;
   localparam logic [2:0] CAUSE_POR = 3'h1;
   localparam logic [2:0] CAUSE_SW = 3'h2;
   localparam logic [2:0] CAUSE_WDOG = 3'h3;
   localparam logic [2:0] CAUSE_PIN = 3'h4;
   localparam logic [2:0] CAUSE_GLOB = 3'h5;
   localparam logic [2:0] CAUSE_LOCAL = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic mr_en;
      logic wdog_en;
      logic sw_rst;
   } rsa_ctrl_t;

   typedef enum logic [1:0] {
      SA_LOCKED = 2'b00,
      SA_FIRST = 2'b01,
      SA_OPEN = 2'b11
   } rsa_safe_t;

   typedef enum logic [1:0] {
      WK_IDLE = 2'b00,
      WK_SHUT = 2'b01,
      WK_SLEEP = 2'b10
   } rsa_wake_t;

endpackage : rsa_pkg

// file: rsa_top.sv
module rsa_top #(
   parameter int WDOG_DIV = rsa_pkg::WDOG_DIV_DEF,
   parameter logic [7:0] CHIP_ID = 8'h5A,  // Arbitrary value
   parameter logic [7:0] SAFE_ID = 8'h3C   // Arbitrary value
) (
   // Clock and power-on reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset sources
   input wire logic rst_pin_n,
   input wire logic shutdown_wake,
   input wire logic sleep_wake,
   input wire logic pwr_ready,
   // Reset and status outputs
   output logic sys_rst_n,
   output logic glob_rst_n,
   output logic local_rst_n,
   output logic safe_act,
   output logic rom_code_offset_bit
);
   import rsa_pkg::*;

   localparam int PRE_W = $clog2(WDOG_DIV);

   function automatic logic is_idx(input logic [11:0] a,
                                   input logic [7:0] idx);
      is_idx = (a[11:10] == 2'b00) && (a[9:2] == idx) && (a[1:0] == 2'b00);
   endfunction : is_idx

   ////////////////////////////////////////////////////////////////////////
   // State
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   rsa_safe_t safe_reg, safe_next;
   logic safe_act_reg;
   logic [3:0] win_reg;
   rsa_ctrl_t ctrl_reg;
   logic [7:0] wdog_reg;
   logic [PRE_W-1:0] pre_reg;
   logic [7:0] mr_cnt_reg;
   logic mr_done_reg;
   rsa_wake_t wake_reg;
   logic sys_rst_n_reg, glob_reg, glob_rst_n_reg, local_rst_n_reg;
   logic [4:0] rst_cnt_reg, loc_cnt_reg;
   logic [2:0] cause_reg;
   logic [7:0] hold_reg;
   logic rom_reg;

   logic wr_ok, sig_wr, prot_ok, tick, wdog_ovf, mr_fire;
   logic glob_req, loc_req, sys_req, sys_clr, glob_clr, loc_clr;
   logic [31:0] rd_data;
   logic map_ok;

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, write lands on the pready edge
   assign wr_ok = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   assign sig_wr = wr_ok & is_idx(paddr, IDX_SIG);
   assign prot_ok = wr_ok & safe_act_reg;

   always_comb begin
      map_ok = 1'b1;
      rd_data = 32'h0000_0000;
      if (is_idx(paddr, IDX_SIG)) begin
         rd_data = {24'h00_0000, 1'b0, win_reg[3:1], safe_act_reg, 1'b0,
                    {2{safe_act_reg}}};
      end else if (is_idx(paddr, IDX_CHIP)) begin
         rd_data = {24'h00_0000, CHIP_ID};
      end else if (is_idx(paddr, IDX_SAFE_ID)) begin
         rd_data = {24'h00_0000, SAFE_ID};
      end else if (is_idx(paddr, IDX_WDOG)) begin
         rd_data = {24'h00_0000, wdog_reg};
      end else if (is_idx(paddr, IDX_STATUS)) begin
         rd_data = {29'h0000_0000, cause_reg};
      end else if (is_idx(paddr, IDX_CTRL)) begin
         rd_data = {29'h0000_0000, ctrl_reg};
      end else if (is_idx(paddr, IDX_HOLD)) begin
         rd_data = {24'h00_0000, hold_reg};
      end else if (is_idx(paddr, IDX_ROM)) begin
         rd_data = {31'h0000_0000, rom_reg};
      end else begin
         map_ok = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (psel && penable && !pready_reg) begin
         pready_reg <= 1'b1;
         pslverr_reg <= ~map_ok;
         prdata_reg <= (pwrite || !map_ok) ? 32'h0000_0000 : rd_data;
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Safe-access unlock sequence
   always_comb begin
      safe_next = safe_reg;
      if (sig_wr) begin
         if (safe_reg == SA_LOCKED && pwdata[7:0] == KEY_FIRST) begin
            safe_next = SA_FIRST;
         end else if (safe_reg == SA_FIRST && pwdata[7:0] == KEY_SECOND) begin
            safe_next = SA_OPEN;
         end else if (pwdata[7:0] == KEY_FIRST) begin
            safe_next = SA_FIRST;
         end else begin
            safe_next = SA_LOCKED;
         end
      end else if (safe_reg == SA_OPEN && win_reg == 4'h0) begin
         safe_next = SA_LOCKED;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         safe_reg <= SA_LOCKED;
         safe_act_reg <= 1'b0;
         win_reg <= 4'h0;
      end else if (sys_clr || loc_clr) begin
         safe_reg <= SA_LOCKED;
         safe_act_reg <= 1'b0;
         win_reg <= 4'h0;
      end else begin
         case (safe_next)
            SA_LOCKED, SA_FIRST: begin
               safe_reg <= safe_next;
               safe_act_reg <= 1'b0;
               win_reg <= 4'h0;
            end
            SA_OPEN: begin
               safe_reg <= SA_OPEN;
               safe_act_reg <= 1'b1;
               win_reg <= (safe_reg == SA_OPEN) ? win_reg - 4'h1
                                                : SAFE_LOAD;
            end
            default: begin
               safe_reg <= SA_LOCKED;
               safe_act_reg <= 1'b0;
               win_reg <= 4'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protected control register, software reset bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
      end else if (sys_clr) begin
         ctrl_reg <= '0;
      end else if (prot_ok && is_idx(paddr, IDX_CTRL)) begin
         ctrl_reg <= rsa_ctrl_t'(pwdata[2:0]);
      end else begin
         ctrl_reg.sw_rst <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog prescaler and counter; regenerative on sleep wake
   assign tick = (pre_reg == PRE_W'(WDOG_DIV - 1));
   assign wdog_ovf = tick & (wdog_reg == 8'hFF) & ctrl_reg.wdog_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_reg <= '0;
      end else if (sys_clr || loc_clr || tick) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + PRE_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_reg <= WDOG_RST;
      end else if (sys_clr || loc_clr) begin
         wdog_reg <= WDOG_RST;
      end else if (wr_ok && is_idx(paddr, IDX_WDOG)) begin
         wdog_reg <= pwdata[7:0];
      end else if (tick) begin
         wdog_reg <= wdog_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Manual reset pin filter
   assign mr_fire = ctrl_reg.mr_en & ~rst_pin_n & ~mr_done_reg
                    & (mr_cnt_reg == MR_CYC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mr_cnt_reg <= 8'h00;
         mr_done_reg <= 1'b0;
      end else if (rst_pin_n) begin
         mr_cnt_reg <= 8'h00;
         mr_done_reg <= 1'b0;
      end else begin
         if (mr_cnt_reg != MR_CYC) begin
            mr_cnt_reg <= mr_cnt_reg + 8'h01;
         end
         if (mr_fire) begin
            mr_done_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake sequencing: wait for power ready before resetting
   assign glob_req = (wake_reg == WK_SHUT) & pwr_ready;
   assign loc_req = (wake_reg == WK_SLEEP) & pwr_ready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_reg <= WK_IDLE;
      end else begin
         case (wake_reg)
            WK_IDLE: begin
               if (shutdown_wake) begin
                  wake_reg <= WK_SHUT;
               end else if (sleep_wake) begin
                  wake_reg <= WK_SLEEP;
               end
            end
            WK_SHUT, WK_SLEEP: begin
               if (pwr_ready) begin
                  wake_reg <= WK_IDLE;
               end
            end
            default: wake_reg <= WK_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset pulse sequencer and cause
   assign sys_req = ctrl_reg.sw_rst | wdog_ovf | mr_fire | glob_req;
   assign sys_clr = ~sys_rst_n_reg;
   assign glob_clr = ~sys_rst_n_reg & glob_reg;
   assign loc_clr = ~local_rst_n_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_rst_n_reg <= 1'b0;
         glob_reg <= 1'b1;
         glob_rst_n_reg <= 1'b0;
         rst_cnt_reg <= SYS_RST_CYC;
         cause_reg <= CAUSE_POR;
      end else if (!sys_rst_n_reg) begin
         rst_cnt_reg <= rst_cnt_reg - 5'h01;
         if (rst_cnt_reg == 5'h01) begin
            sys_rst_n_reg <= 1'b1;
            glob_reg <= 1'b0;
            glob_rst_n_reg <= 1'b1;
         end
      end else if (sys_req) begin
         sys_rst_n_reg <= 1'b0;
         rst_cnt_reg <= SYS_RST_CYC;
         glob_reg <= glob_req;
         glob_rst_n_reg <= ~glob_req;
         if (glob_req) begin
            cause_reg <= CAUSE_GLOB;
         end else if (mr_fire) begin
            cause_reg <= CAUSE_PIN;
         end else if (wdog_ovf) begin
            cause_reg <= CAUSE_WDOG;
         end else begin
            cause_reg <= CAUSE_SW;
         end
      end else if (loc_req) begin
         cause_reg <= CAUSE_LOCAL;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_rst_n_reg <= 1'b1;
         loc_cnt_reg <= 5'h00;
      end else if (loc_req && sys_rst_n_reg && !sys_req) begin
         local_rst_n_reg <= 1'b0;
         loc_cnt_reg <= LOC_RST_CYC;
      end else if (!local_rst_n_reg) begin
         loc_cnt_reg <= loc_cnt_reg - 5'h01;
         if (loc_cnt_reg == 5'h01) begin
            local_rst_n_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Retained registers: cleared only by power-on or shutdown wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= HOLD_RST;
         rom_reg <= 1'b0;
      end else if (glob_clr) begin
         hold_reg <= HOLD_RST;
         rom_reg <= 1'b0;
      end else begin
         if (wr_ok && is_idx(paddr, IDX_HOLD)) begin
            hold_reg <= pwdata[7:0];
         end
         if (prot_ok && is_idx(paddr, IDX_ROM)) begin
            rom_reg <= pwdata[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sys_rst_n = sys_rst_n_reg;
   assign glob_rst_n = glob_rst_n_reg;
   assign local_rst_n = local_rst_n_reg;
   assign safe_act = safe_act_reg;
   assign rom_code_offset_bit = rom_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_sw_clear;
      @(posedge pclk) disable iff (!presetn)
      ctrl_reg.sw_rst |=> !ctrl_reg.sw_rst;
   endproperty
   a_sw_clear: assert property (p_sw_clear)
      else $error("software reset bit did not clear");

   property p_sw_reset;
      @(posedge pclk) disable iff (!presetn)
      ctrl_reg.sw_rst && sys_rst_n_reg |=> !sys_rst_n_reg;
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("software reset not applied");

   property p_unlock;
      @(posedge pclk) disable iff (!presetn)
      sig_wr && safe_reg == SA_FIRST && pwdata[7:0] == KEY_SECOND
         && sys_rst_n_reg && local_rst_n_reg
      |=> safe_act_reg && win_reg == SAFE_LOAD;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("unlock sequence did not open");

   property p_expire;
      @(posedge pclk) disable iff (!presetn)
      $rose(safe_act_reg) |-> ##(SAFE_CYC) !safe_act_reg;
   endproperty
   a_expire: assert property (p_expire)
      else $error("safe window outlived its limit");

   property p_exit;
      @(posedge pclk) disable iff (!presetn)
      sig_wr && pwdata[7:0] == KEY_EXIT |=> !safe_act_reg;
   endproperty
   a_exit: assert property (p_exit)
      else $error("exit byte did not relock");

   property p_protect;
      @(posedge pclk) disable iff (!presetn)
      wr_ok && is_idx(paddr, IDX_CTRL) && !safe_act_reg && sys_rst_n_reg
      |=> $stable(ctrl_reg.wdog_en) && $stable(ctrl_reg.mr_en);
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected write accepted while locked");

   property p_wdog;
      @(posedge pclk) disable iff (!presetn)
      wdog_ovf && sys_rst_n_reg && !glob_req && !mr_fire
      |=> !sys_rst_n_reg && cause_reg == CAUSE_WDOG;
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("watchdog overflow did not reset");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      tick && wdog_reg == 8'hFF && sys_rst_n_reg && local_rst_n_reg
         && !(wr_ok && is_idx(paddr, IDX_WDOG))
      |=> wdog_reg == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("watchdog did not wrap to zero");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      !sys_rst_n_reg && !glob_reg && !wr_ok |=> $stable(hold_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold register lost on non-global reset");

   property p_local;
      @(posedge pclk) disable iff (!presetn)
      !local_rst_n_reg && sys_rst_n_reg && !ctrl_reg.sw_rst && !prot_ok
      |=> $stable(ctrl_reg) && wdog_reg == WDOG_RST;
   endproperty
   a_local: assert property (p_local)
      else $error("local reset touched retained control");

   property p_pin;
      @(posedge pclk) disable iff (!presetn)
      mr_fire && sys_rst_n_reg && !glob_req |=> !sys_rst_n_reg
         && cause_reg == CAUSE_PIN;
   endproperty
   a_pin: assert property (p_pin)
      else $error("manual pin reset not applied");

endmodule : rsa_top

// file: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rsa_pkg::*;

   localparam int DIV = 8;
   localparam logic [7:0] CHIP = 8'h5A;  // Arbitrary value
   localparam logic [7:0] SAFE = 8'h3C;  // Arbitrary value
   localparam int LIMIT = 20000;

   ////////////////////////////////////////////////////////////////////////
   // Signals
   logic pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr;
   logic rst_pin_n, shutdown_wake, sleep_wake, pwr_ready;
   logic sys_rst_n, glob_rst_n, local_rst_n, safe_act, rom_code_offset_bit;
   int n_errors, total_checks, cycles, n;
   logic [31:0] r, a;
   logic e;

   rsa_top #(.WDOG_DIV(DIV), .CHIP_ID(CHIP), .SAFE_ID(SAFE)) u_rsa_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n),
      .shutdown_wake(shutdown_wake), .sleep_wake(sleep_wake),
      .pwr_ready(pwr_ready), .sys_rst_n(sys_rst_n), .glob_rst_n(glob_rst_n),
      .local_rst_n(local_rst_n), .safe_act(safe_act),
      .rom_code_offset_bit(rom_code_offset_bit)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock and timeout
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic chk_val(input string nm, input logic [31:0] exp,
                          input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_val

   task automatic chk_cnt(input string nm, input int exp, input int got);
      total_checks++;
      if (got != exp) begin
         n_errors++;
         $display("BAD %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk_cnt

   task automatic results();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////
   // APB master
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [31:0] rd_v,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Waits for the answer; only the bench timeout ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] t;
      logic te;
      apb(1'b1, idx, d, t, te);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] idx,
                         input logic [7:0] exp);
      logic [31:0] t;
      logic te;
      apb(1'b0, idx, 8'h00, t, te);
      chk_val(nm, {24'h000000, exp}, t);
   endtask : rd_chk

   task automatic unlock();
      wr(IDX_SIG, KEY_FIRST);
      wr(IDX_SIG, KEY_SECOND);
   endtask : unlock

   task automatic safe_after(input logic exp);
      repeat (2) @(posedge pclk);
      chk_val("safe_act", {31'h0, exp}, {31'h0, safe_act});
   endtask : safe_after

   function automatic logic sig(input int w);
      case (w)
         0: return sys_rst_n;
         1: return local_rst_n;
         default: return glob_rst_n;
      endcase
   endfunction : sig

   // Waits for a low pulse and returns its length in cycles
   task automatic low_len(input int w, output int len);
      int k;
      len = 0;
      for (k = 0; k < 400 && sig(w) !== 1'b0; k++) @(posedge pclk);
      while (sig(w) === 1'b0 && len < 400) begin
         @(posedge pclk);
         len++;
      end
      repeat (2) @(posedge pclk);
   endtask : low_len

   // Counts cycles in which a reset output is not high
   task automatic quiet(input int w, input int len, output int lows);
      lows = 0;
      repeat (len) begin
         @(posedge pclk);
         if (sig(w) !== 1'b1) lows++;
      end
   endtask : quiet

   ////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      n_errors = 0;
      total_checks = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      rst_pin_n = 1'b1;
      shutdown_wake = 1'b0;
      sleep_wake = 1'b0;
      pwr_ready = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      low_len(2, n);
      // Counted from the release edge, one more than the pulse
      chk_cnt("por_len", int'(SYS_RST_CYC) + 1, n);
      rd_chk("status_por", IDX_STATUS, {5'h00, CAUSE_POR});
      rd_chk("chip_id", IDX_CHIP, CHIP);
      rd_chk("safe_id", IDX_SAFE_ID, SAFE);
      rd_chk("sig_locked", IDX_SIG, 8'h00);
      wr(IDX_CHIP, 8'h00);
      rd_chk("chip_ro", IDX_CHIP, CHIP);
      wr(IDX_CTRL, 8'h02);
      rd_chk("ctrl_locked", IDX_CTRL, 8'h00);
      unlock();
      wr(IDX_ROM, 8'h01);
      wr(IDX_CTRL, 8'h04);
      rd_chk("rom_open", IDX_ROM, 8'h01);
      rd_chk("ctrl_open", IDX_CTRL, 8'h04);
      chk_val("rom_pin", 32'h1, {31'h0, rom_code_offset_bit});
      repeat (20) @(posedge pclk);
      unlock();
      n = 0;
      repeat (40) begin
         @(posedge pclk);
         if (safe_act === 1'b1) n++;
      end
      chk_cnt("window", SAFE_CYC, n);
      wr(IDX_ROM, 8'h00);
      rd_chk("rom_expired", IDX_ROM, 8'h01);
      unlock();
      apb(1'b0, IDX_SIG, 8'h00, r, e);
      chk_val("sig_open", 32'h0000000B, r & 32'hFFFFFF8F);
      wr(IDX_SIG, KEY_EXIT);
      safe_after(1'b0);
      rd_chk("sig_exit", IDX_SIG, 8'h00);
      unlock();
      wr(IDX_SIG, 8'h33);
      safe_after(1'b0);
      wr(IDX_SIG, KEY_FIRST);
      wr(IDX_SIG, 8'h33);
      wr(IDX_SIG, KEY_SECOND);
      safe_after(1'b0);
      wr(IDX_HOLD, 8'hA5);
      rd_chk("hold", IDX_HOLD, 8'hA5);
      // Software reset
      unlock();
      wr(IDX_CTRL, 8'h01);
      low_len(0, n);
      chk_cnt("sw_len", int'(SYS_RST_CYC), n);
      chk_val("glob_kept", 32'h1, {31'h0, glob_rst_n});
      rd_chk("status_sw", IDX_STATUS, {5'h00, CAUSE_SW});
      rd_chk("ctrl_clear", IDX_CTRL, 8'h00);
      rd_chk("hold_sw", IDX_HOLD, 8'hA5);
      rd_chk("rom_sw", IDX_ROM, 8'h01);
      // Watchdog rate and wrap
      wr(IDX_WDOG, 8'hFC);
      apb(1'b0, IDX_WDOG, 8'h00, a, e);
      repeat (8 * DIV - 4) @(posedge pclk);
      apb(1'b0, IDX_WDOG, 8'h00, r, e);
      chk_val("wdog_step", {24'h0, a[7:0] + 8'h08}, r);
      chk_val("wdog_no_rst", 32'h1, {31'h0, sys_rst_n});
      // Watchdog timeout reset
      unlock();
      wr(IDX_CTRL, 8'h02);
      wr(IDX_WDOG, 8'hFF);
      low_len(0, n);
      chk_cnt("wdog_len", int'(SYS_RST_CYC), n);
      rd_chk("status_wdog", IDX_STATUS, {5'h00, CAUSE_WDOG});
      rd_chk("hold_wdog", IDX_HOLD, 8'hA5);
      // Manual pin reset
      unlock();
      wr(IDX_CTRL, 8'h04);
      @(posedge pclk);
      rst_pin_n <= 1'b0;
      repeat (20) @(posedge pclk);
      rst_pin_n <= 1'b1;
      quiet(0, 8, n);
      chk_cnt("pin_short", 0, n);
      rst_pin_n <= 1'b0;
      low_len(0, n);
      chk_cnt("pin_len", int'(SYS_RST_CYC), n);
      rst_pin_n <= 1'b1;
      rd_chk("status_pin", IDX_STATUS, {5'h00, CAUSE_PIN});
      // Sleep wake local reset
      unlock();
      wr(IDX_CTRL, 8'h04);
      wr(IDX_HOLD, 8'h11);
      wr(IDX_WDOG, 8'h80);
      @(posedge pclk);
      pwr_ready <= 1'b0;
      sleep_wake <= 1'b1;
      @(posedge pclk);
      sleep_wake <= 1'b0;
      quiet(1, 10, n);
      chk_cnt("sleep_wait", 0, n);
      pwr_ready <= 1'b1;
      low_len(1, n);
      chk_cnt("local_len", int'(LOC_RST_CYC), n);
      chk_val("sleep_sys", 32'h1, {31'h0, sys_rst_n});
      apb(1'b0, IDX_WDOG, 8'h00, r, e);
      chk_val("wdog_wake", 32'h0, r & 32'hFFFFFFF0);
      rd_chk("ctrl_kept", IDX_CTRL, 8'h04);
      rd_chk("hold_sleep", IDX_HOLD, 8'h11);
      rd_chk("status_loc", IDX_STATUS, {5'h00, CAUSE_LOCAL});
      // Shutdown wake global reset
      @(posedge pclk);
      pwr_ready <= 1'b0;
      shutdown_wake <= 1'b1;
      @(posedge pclk);
      shutdown_wake <= 1'b0;
      quiet(0, 10, n);
      chk_cnt("shut_wait", 0, n);
      pwr_ready <= 1'b1;
      low_len(2, n);
      chk_cnt("glob_len", int'(SYS_RST_CYC), n);
      rd_chk("status_glob", IDX_STATUS, {5'h00, CAUSE_GLOB});
      rd_chk("hold_glob", IDX_HOLD, HOLD_RST);
      rd_chk("rom_glob", IDX_ROM, 8'h00);
      rd_chk("ctrl_glob", IDX_CTRL, 8'h00);
      // Unmapped index
      apb(1'b0, 8'h45, 8'h00, r, e);
      chk_val("unmapped", 32'h1, {31'h0, e});
      results();
   end

endmodule : tb
